// ---- host_port_and_reset.sv ----
// Parallel host port with device reset behaviour
//
// Function
// - Direction/strobe style: acknowledge driven low marks transfer complete.
// - Separate strobe style: acknowledge low-to-high transition marks completion.
// - Select low enables access; strobes ignored while select is high.
// - Direction high means read, low means write; data bus direction follows.
// - Separate style: write strobe low requests a write access.
// - Direction/strobe style: access only while data strobe and select both low.
// - Separate style: read strobe low requests a read; data driven out.
// - A 14-bit address selects among internal registers and memories.
// - 16-bit data words move both ways, reads and writes supported.
// - Style pin high or open picks direction/strobe style, low picks separate.
// - During reset serial output drivers are off, high-impedance controls high.
// - Reset loads register defaults and clears all internal counters.
`timescale 1ns/1ns
`include "host_port_params.svh"
module host_port_and_reset
#(
  parameter int ADDR_W     = `ADDR_W,
  parameter int DATA_W     = `DATA_W,
  parameter int WORDS      = `MEM_WORDS,
  parameter int STABLE_CYC = `STABLE_CYC,
  parameter int STREAMS    = `STREAM_COUNT,
  parameter int HIZ_OUTS   = `HIZ_COUNT
)
(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                reset_n,
  // Host control pins
  input  wire logic                select_n,
  input  wire logic                dir_or_write_n,
  input  wire logic                data_or_read_strobe,
  input  wire logic                bus_style_select,
  input  wire logic [ADDR_W-1:0]   addr_lines,
  // Data bus, three signals per pin
  input  wire logic [DATA_W-1:0]   data_lines_in,
  output logic      [DATA_W-1:0]   data_lines_out,
  output logic                     data_lines_oe_n,
  // Transfer acknowledge, three-state
  output logic                     transfer_ack_out,
  output logic                     transfer_ack_oe_n,
  // Output stream gating toward the datapath
  output logic                     serial_out_enable,
  output logic      [HIZ_OUTS-1:0] ext_hiz_controls_force,
  // Device has settled after reset
  output logic                     port_ready
);

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  localparam int PW = ADDR_W + DATA_W + 4;

  logic [PW-1:0] pins_raw;
  logic [PW-1:0] pins_sync;
  logic [PW-1:0] pins_idle;
  host_port_pkg::host_pins_t pins;
  host_port_pkg::bus_style_t style;

  assign pins_raw  = {select_n, dir_or_write_n, data_or_read_strobe, addr_lines,
                      data_lines_in, bus_style_select};
  assign pins_idle = {3'b111, {ADDR_W{1'b0}}, {DATA_W{1'b0}}, 1'b1};

  pin_sync #(.WIDTH(PW)) u_sync
  (
    .clk        (clk),
    .reset_n    (reset_n),
    .async_in   (pins_raw),
    .sync_out   (pins_sync),
    .idle_value (pins_idle)
  );

  // Style pin high or floating selects direction/strobe
  assign pins  = host_port_pkg::host_pins_t'(pins_sync[PW-1:1]);
  assign style = pins_sync[0] ? host_port_pkg::STYLE_DIR_STROBE
                              : host_port_pkg::STYLE_SEPARATE;

  //////////////////////////////////////////////////////////////////////////////
  // Style decoding shared by the decode and the acknowledge logic

  // Direction-plus-strobe style; one definition keeps both paths in step
  function automatic logic is_dir_style(input host_port_pkg::bus_style_t s);
    return (s == host_port_pkg::STYLE_DIR_STROBE);
  endfunction

  // Acknowledge level while busy; completion shows the opposite level
  // Direction style idles high and falls, separate style idles low and rises
  function automatic logic busy_ack_level(input host_port_pkg::bus_style_t s);
    return is_dir_style(s);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Access decode

  logic active;
  logic is_write;

  // Strobes only count with select low
  always_comb
  begin
    if (is_dir_style(style))
    begin
      active   = !pins.select_n && !pins.data_or_read_strobe;
      is_write = !pins.dir_or_write_n;
    end
    else
    begin
      active   = !pins.select_n && (!pins.data_or_read_strobe || !pins.dir_or_write_n);
      is_write = !pins.dir_or_write_n;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Settle counter after reset

  localparam int SW = $clog2(STABLE_CYC + 1);

  logic [SW-1:0] settle_cnt;
  logic [SW-1:0] next_settle_cnt;
  logic          next_port_ready;

  // Host is expected to wait; accesses before settling are ignored
  always_comb
  begin
    next_settle_cnt = settle_cnt;
    if (settle_cnt != SW'(STABLE_CYC))
    begin
      next_settle_cnt = settle_cnt + SW'(1);
    end
    next_port_ready = (next_settle_cnt == SW'(STABLE_CYC));
  end

  // Count restarts from zero on every reset, not only at power-up
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      settle_cnt <= '0;
      port_ready <= 1'b0;
    end
    else
    begin
      settle_cnt <= next_settle_cnt;
      port_ready <= next_port_ready;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Access state machine

  typedef enum logic [1:0]
  {
    S_IDLE,
    S_WAIT,
    S_DONE
  } acc_state_t;

  acc_state_t             state;
  acc_state_t             next_state;
  host_port_pkg::mem_req_t req;
  host_port_pkg::mem_req_t next_req;
  logic [1:0]             lat_cnt;
  logic [1:0]             next_lat_cnt;
  logic [DATA_W-1:0]      mem_rdata;
  logic [DATA_W-1:0]      next_data_out;
  logic                   next_data_oe_n;
  logic                   next_ack_out;
  logic                   next_ack_oe_n;

  // One access per strobe; next one needs the strobe released first
  always_comb
  begin
    next_state     = state;
    next_req       = req;
    next_req.valid = 1'b0;
    next_lat_cnt   = lat_cnt;
    next_data_out  = data_lines_out;
    next_data_oe_n = 1'b1;
    next_ack_out   = 1'b0;
    next_ack_oe_n  = 1'b1;
    unique case (state)
      S_IDLE:
      begin
        if (active && port_ready)
        begin
          next_req.valid = 1'b1;
          next_req.write = is_write;
          next_req.addr  = pins.addr_lines;
          next_req.wdata = pins.data_lines;
          next_lat_cnt   = 2'(`ACCESS_LAT);
          next_state     = S_WAIT;
          next_ack_oe_n  = 1'b0;
          next_ack_out   = busy_ack_level(style);
          next_data_oe_n = is_write;
        end
      end
      S_WAIT:
      begin
        next_ack_oe_n  = 1'b0;
        next_ack_out   = busy_ack_level(style);
        next_data_oe_n = req.write;
        next_lat_cnt   = lat_cnt - 2'd1;
        if (lat_cnt == 2'd1)
        begin
          next_data_out = mem_rdata;
          next_state    = S_DONE;
        end
      end
      S_DONE:
      begin
        // Low for direction/strobe, rising edge for separate strobes
        next_ack_out   = !busy_ack_level(style);
        next_data_oe_n = req.write;
        next_ack_oe_n  = 1'b0;
        if (!active)
        begin
          next_state     = S_IDLE;
          next_data_oe_n = 1'b1;
          next_ack_oe_n  = 1'b1;
        end
      end
      default:
      begin
        // Unused state code: back to idle with every driver off
        next_state = S_IDLE;
      end
    endcase
  end

  // Reset clears the port back to idle with all drivers off
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state             <= S_IDLE;
      req               <= '0;
      lat_cnt           <= '0;
      data_lines_out    <= '0;
      data_lines_oe_n   <= 1'b1;
      transfer_ack_out  <= 1'b0;
      transfer_ack_oe_n <= 1'b1;
    end
    else
    begin
      state             <= next_state;
      req               <= next_req;
      lat_cnt           <= next_lat_cnt;
      data_lines_out    <= next_data_out;
      data_lines_oe_n   <= next_data_oe_n;
      transfer_ack_out  <= next_ack_out;
      transfer_ack_oe_n <= next_ack_oe_n;
    end
  end

  // Request is registered first, so read data lands one edge after the take
  reg_mem #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .WORDS(WORDS)) u_mem
  (
    .clk   (clk),
    .wr_en (req.valid && req.write),
    .rd_en (req.valid && !req.write),
    .addr  (req.addr),
    .wdata (req.wdata),
    .rdata (mem_rdata)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Output stream gating during reset

  logic                next_serial_out_enable;
  logic [HIZ_OUTS-1:0] next_hiz_force;

  // Drivers return one edge after release; no buffer sees a glitch low
  always_comb
  begin
    next_serial_out_enable = 1'b1;
  end

  // One forcing bit per external buffer control, all released together
  for (genvar g = 0; g < HIZ_OUTS; g++)
  begin : g_hiz
    assign next_hiz_force[g] = 1'b0;
  end

  // Synchronous reset, so gating follows reset by one edge
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      serial_out_enable      <= 1'b0;
      ext_hiz_controls_force <= {HIZ_OUTS{1'b1}};
    end
    else
    begin
      serial_out_enable      <= next_serial_out_enable;
      ext_hiz_controls_force <= next_hiz_force;
    end
  end

endmodule

// ---- host_port_params.svh ----
// Constants for the parallel host port and reset block
`ifndef HOST_PORT_PARAMS_SVH
`define HOST_PORT_PARAMS_SVH

`define ADDR_W             14
`define DATA_W             16
`define CLK_PERIOD_NS      10
`define RESET_MIN_NS       1000
`define RESET_MIN_CYC      ((`RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STABLE_US          600
`define STABLE_CYC         ((`STABLE_US * 1000) / `CLK_PERIOD_NS)
`define MEM_WORDS          16384
`define ACCESS_LAT         2
`define STREAM_COUNT       32
`define HIZ_COUNT          16

`endif

// ---- host_port_pkg.sv ----
// Types shared by the parallel host port and reset block
package host_port_pkg;

  // Host pin bundle after synchronisation
  typedef struct packed
  {
    logic        select_n;
    logic        dir_or_write_n;
    logic        data_or_read_strobe;
    logic [13:0] addr_lines;
    logic [15:0] data_lines;
  } host_pins_t;

  // Request to the storage behind the port
  typedef struct packed
  {
    logic        valid;
    logic        write;
    logic [13:0] addr;
    logic [15:0] wdata;
  } mem_req_t;

  typedef enum logic
  {
    STYLE_SEPARATE,
    STYLE_DIR_STROBE
  } bus_style_t;

endpackage

// ---- pin_sync.sv ----
// Two-stage synchroniser for a group of pins
`timescale 1ns/1ns
module pin_sync
#(
  parameter int WIDTH = 1
)
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Pins in, synchronised out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out,
  // Value loaded during reset
  input  wire logic [WIDTH-1:0] idle_value
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync_out;

  // First stage feeds only the second
  always_comb
  begin
    next_stage1   = async_in;
    next_sync_out = stage1;
  end

  // Idle value is a tie-off constant at the instance
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      stage1   <= idle_value;
      sync_out <= idle_value;
    end
    else
    begin
      stage1   <= next_stage1;
      sync_out <= next_sync_out;
    end
  end

endmodule

// ---- reg_mem.sv ----
// Word memory behind the host port, registered read data
`timescale 1ns/1ns
module reg_mem
#(
  parameter int ADDR_W = 14,
  parameter int DATA_W = 16,
  parameter int WORDS  = 16384
)
(
  // Clock
  input  wire logic              clk,
  // Access
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  output logic      [DATA_W-1:0] rdata
);

  logic [DATA_W-1:0] store [WORDS];

  // Storage array has no reset; defaults live in the port's registers
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      store[addr] <= wdata;
    end
    if (rd_en)
    begin
      rdata <= store[addr];
    end
  end

endmodule

// ---- host_port_and_reset_asserts.sv ----
// Checker for the host port and reset block
`timescale 1ns/1ns
module host_port_checks
#(
  parameter int HIZ_OUTS = 16
)
(
  // Clock, reset and watched pins
  input wire logic                clk,
  input wire logic                reset_n,
  input wire logic                select_n,
  input wire logic                dir_or_write_n,
  input wire logic                bus_style_select,
  input wire logic                data_lines_oe_n,
  input wire logic                transfer_ack_out,
  input wire logic                transfer_ack_oe_n,
  input wire logic                serial_out_enable,
  input wire logic [HIZ_OUTS-1:0] ext_hiz_controls_force,
  input wire logic                port_ready
);
  ////////////////////////////////
  // One domain, so clock and disable are shared
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Reset itself is watched, so no disable here
  chk_reset_quiet: assert property (disable iff (1'b0) !reset_n |=>
    !serial_out_enable && (&ext_hiz_controls_force) && !port_ready)
    else $error("outputs not quiet in reset");
  chk_run_enable: assert property ($past(reset_n) |->
    serial_out_enable && ext_hiz_controls_force == '0)
    else $error("streams not released after reset");
  chk_idle_float: assert property (select_n [*5] |->
    transfer_ack_oe_n && data_lines_oe_n)
    else $error("pins driven while deselected");
  chk_unready_quiet: assert property (!port_ready |-> transfer_ack_oe_n)
    else $error("ack before settle");
  chk_dir_done: assert property (bus_style_select && $fell(transfer_ack_oe_n) |->
    transfer_ack_out ##3 !transfer_ack_out && !transfer_ack_oe_n)
    else $error("direction style ack wrong");
  chk_sep_done: assert property (!bus_style_select && $fell(transfer_ack_oe_n) |->
    !transfer_ack_out ##3 transfer_ack_out && !transfer_ack_oe_n)
    else $error("separate style ack wrong");
  chk_write_no_drive: assert property ($fell(transfer_ack_oe_n) && !dir_or_write_n |->
    data_lines_oe_n [*4])
    else $error("data driven on write");
  chk_read_drive: assert property ($fell(transfer_ack_oe_n) && dir_or_write_n |->
    !data_lines_oe_n [*4])
    else $error("data not driven on read");
endmodule

bind host_port_and_reset host_port_checks #(.HIZ_OUTS(HIZ_OUTS)) u_host_port_checks (
  .clk(clk), .reset_n(reset_n), .select_n(select_n), .dir_or_write_n(dir_or_write_n),
  .bus_style_select(bus_style_select), .data_lines_oe_n(data_lines_oe_n),
  .transfer_ack_out(transfer_ack_out), .transfer_ack_oe_n(transfer_ack_oe_n),
  .serial_out_enable(serial_out_enable), .ext_hiz_controls_force(ext_hiz_controls_force),
  .port_ready(port_ready));

// ---- host_cpu_model.sv ----
// Host processor model for the parallel port
`timescale 1ns/1ns
module host_cpu_model
(
  // Clock and style pin
  input  wire logic        clk,
  input  wire logic        bus_style_select,
  // Device side of the pins
  input  wire logic [15:0] data_lines_out,
  input  wire logic        data_lines_oe_n,
  input  wire logic        transfer_ack_out,
  input  wire logic        transfer_ack_oe_n,
  // Pins driven by the host
  output logic             select_n,
  output logic             dir_or_write_n,
  output logic             data_or_read_strobe,
  output logic      [13:0] addr_lines,
  output logic      [15:0] data_lines_in
);
  logic        hdrive;
  logic [15:0] hdata;
  logic        ack_wire;
  ////////////////////////////////
  // Floating ack sits at the pull level of the style
  assign ack_wire = transfer_ack_oe_n ? bus_style_select : transfer_ack_out;
  // Released bus shows the inverse of the last value, never a stale match
  assign data_lines_in = !data_lines_oe_n ? data_lines_out : (hdrive ? hdata : ~hdata);
  initial
  begin
    {select_n, dir_or_write_n, data_or_read_strobe} = 3'h7;
    addr_lines = 14'h0000;
    hdrive = 1'b0;
    hdata = 16'h0000;
  end
  // One access; request held until the completion level is sampled or 12 cycles pass
  task automatic access(input logic wr, input logic sel_n, input logic [13:0] a,
                        input logic [15:0] d, output logic [15:0] rd, output logic acked);
    int i;
    @(posedge clk);
    select_n <= sel_n;
    dir_or_write_n <= !wr;
    data_or_read_strobe <= bus_style_select ? 1'b0 : wr;
    addr_lines <= a;
    hdrive <= wr;
    if (wr)
      hdata <= d;
    acked = 1'b0;
    for (i = 0; i < 12 && !acked; i++)
    begin
      @(posedge clk);
      acked = (ack_wire === !bus_style_select);
      rd = data_lines_in;
    end
    {select_n, dir_or_write_n, data_or_read_strobe} <= 3'h7;
    hdrive <= 1'b0;
    for (i = 0; i < 8 && transfer_ack_oe_n !== 1'b1; i++)
      @(posedge clk);
  endtask
endmodule

// ---- test_host_port_and_reset.sv ----
// Self-checking bench for the host port and reset block
`timescale 1ns/1ns
`include "host_port_params.svh"
module test_host_port_and_reset;
  typedef struct packed {logic style; logic wr; logic [13:0] addr; logic [15:0] data;} row_t;
  localparam int STABLE = 20;
  logic        clk, reset_n, bus_style_select, select_n, dir_or_write_n, strobe, acked;
  logic        data_oe_n, ack_out, ack_oe_n, serial_en, port_ready;
  logic [13:0] addr_lines;
  logic [15:0] din, dout, hiz, rd;
  int          err_total, tests_run, cycles, n;
  row_t        rows [7] = '{{1'b1, 1'b1, 14'h0000, 16'hA5A5}, {1'b1, 1'b1, 14'h3FFF, 16'h5A5A},
    {1'b0, 1'b1, 14'h1234, 16'hC3C3}, {1'b1, 1'b0, 14'h0000, 16'hA5A5},
    {1'b0, 1'b0, 14'h3FFF, 16'h5A5A}, {1'b1, 1'b0, 14'h1234, 16'hC3C3},
    {1'b0, 1'b0, 14'h0000, 16'hA5A5}};
  ////////////////////////////////
  host_port_and_reset #(.STABLE_CYC(STABLE)) u_host_port_and_reset (.clk(clk),
    .reset_n(reset_n), .select_n(select_n), .dir_or_write_n(dir_or_write_n),
    .data_or_read_strobe(strobe), .bus_style_select(bus_style_select),
    .addr_lines(addr_lines), .data_lines_in(din), .data_lines_out(dout),
    .data_lines_oe_n(data_oe_n), .transfer_ack_out(ack_out), .transfer_ack_oe_n(ack_oe_n),
    .serial_out_enable(serial_en), .ext_hiz_controls_force(hiz), .port_ready(port_ready));
  host_cpu_model u_host_cpu_model (.clk(clk), .bus_style_select(bus_style_select),
    .data_lines_out(dout), .data_lines_oe_n(data_oe_n), .transfer_ack_out(ack_out),
    .transfer_ack_oe_n(ack_oe_n), .select_n(select_n), .dir_or_write_n(dir_or_write_n),
    .data_or_read_strobe(strobe), .addr_lines(addr_lines), .data_lines_in(din));
  ////////////////////////////////
  // Clock, and a hang limit well above the expected run
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      err_total++;
      $display("[FAIL] %0t timeout", $time);
      wrap_up();
    end
  end
  // Count and report one comparison
  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1)
    begin
      err_total++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  // Hold reset for the given cycles, check quiet outputs, release
  task automatic do_reset(input int hold);
    reset_n <= 1'b0;
    repeat (hold) @(posedge clk);
    #1;
    check(serial_en === 1'b0 && hiz === 16'hFFFF, "streams not gated");
    check(ack_oe_n === 1'b1 && data_oe_n === 1'b1 && port_ready === 1'b0, "pins busy");
    @(posedge clk);
    reset_n <= 1'b1;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////
  // Main sequence
  initial
  begin
    reset_n = 1'b0;
    bus_style_select = 1'b1;
    do_reset(6);
    u_host_cpu_model.access(1'b1, 1'b0, 14'h0ABC, 16'hFFFF, rd, acked);
    check(acked === 1'b0, "access before settle");
    for (n = 0; n < 40 && port_ready !== 1'b1; n++)
      @(posedge clk);
    check(serial_en === 1'b1 && hiz === 16'h0000, "streams still gated");
    $display("reset test done");
    foreach (rows[i])
    begin
      bus_style_select <= rows[i].style;
      repeat (3) @(posedge clk);
      u_host_cpu_model.access(rows[i].wr, 1'b0, rows[i].addr, rows[i].data, rd, acked);
      check(acked === 1'b1, "no completion");
      if (!rows[i].wr)
        check(rd === rows[i].data, "read data");
    end
    $display("row test done");
    u_host_cpu_model.access(1'b1, 1'b0, 14'h0ABC, 16'h2222, rd, acked);
    u_host_cpu_model.access(1'b1, 1'b1, 14'h0ABC, 16'h1111, rd, acked);
    check(acked === 1'b0, "deselected access acked");
    u_host_cpu_model.access(1'b0, 1'b0, 14'h0ABC, 16'h0000, rd, acked);
    check(rd === 16'h2222, "deselected write landed");
    $display("select test done");
    do_reset(`RESET_MIN_CYC + 1);
    for (n = 0; n < 40 && port_ready !== 1'b1; n++)
      @(posedge clk);
    check(n >= STABLE - 1 && n <= STABLE + 3, "settle time");
    $display("second reset test done");
    wrap_up();
  end
endmodule
